// *** logic/rlsm_pkg.sv ***
// Constants shared by the runway light setting monitor.
// Assumes a 125 MHz system clock and lamp currents reported in milliamps.
package rlsm_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_IN_NS      = 1000000;
  localparam int unsigned TICK_CYCLES   = (MS_IN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Coast limit for a missing channel, in seconds and in millisecond ticks
  localparam int unsigned COAST_LIMIT_S  = 30;
  localparam int unsigned COAST_LIMIT_MS = COAST_LIMIT_S * 1000;
  localparam int unsigned COAST_W        = 15;

  // Default interval between set updates, in millisecond ticks
  localparam int unsigned SAMPLE_PERIOD_MS = 1000;
  localparam int unsigned PERIOD_W         = 16;

  // Channel count, current width and step width
  localparam int unsigned NUM_CH  = 8;
  localparam int unsigned CUR_W   = 16;
  localparam int unsigned STEP_W  = 3;
  localparam int unsigned NUM_THR = 5;

  localparam logic [STEP_W-1:0] STEP_OFF = 3'h0;
  localparam logic [STEP_W-1:0] STEP_MAX = 3'h5;

  // Full-scale lamp current of each circuit type, mA
  localparam logic [CUR_W-1:0] FS_LOW_MA  = 16'h19c8; // 6.6 A
  localparam logic [CUR_W-1:0] FS_HIGH_MA = 16'h4e20; // 20 A
  // Headroom above full scale, as a right shift of full scale (1/16)
  localparam int unsigned OVR_SHIFT = 4;

  // Lowest current of steps 1..5, mA; entry 0 is step 1
  localparam logic [NUM_THR-1:0][CUR_W-1:0] THR_LOW = {
    16'h1770, 16'h12c0, 16'h0ed8, 16'h0c1c, 16'h09c4};
  localparam logic [NUM_THR-1:0][CUR_W-1:0] THR_HIGH = {
    16'h4718, 16'h38a4, 16'h2cec, 16'h24b8, 16'h1db0};

  // Circuit type and set membership encodings
  localparam logic CKT_LOW   = 1'b0;
  localparam logic CKT_HIGH  = 1'b1;
  localparam logic SET_EDGE  = 1'b0;
  localparam logic SET_CLINE = 1'b1;

endpackage

// *** logic/rlsm_chan.sv ***
// Per-channel sample tracker: holds the last valid step and ages it.
// Assumes one-cycle sample strobes and a one-cycle millisecond tick.
`timescale 1ns/1ps
module rlsm_chan #(
  parameter int unsigned COAST_MS = rlsm_pkg::COAST_LIMIT_MS
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        smp_stb,
  input  wire logic                        smp_good,
  input  wire logic [rlsm_pkg::STEP_W-1:0] smp_step,
  input  wire logic                        ms_tick,
  output logic      [rlsm_pkg::STEP_W-1:0] step_out,
  output logic                             valid_out
);

  localparam logic [rlsm_pkg::COAST_W-1:0] COAST_END = COAST_MS[rlsm_pkg::COAST_W-1:0];

  logic [rlsm_pkg::STEP_W-1:0]  held_r,  held_nxt;
  logic [rlsm_pkg::COAST_W-1:0] age_r,   age_nxt;

  // hold last good
  // A good sample refreshes the held step; otherwise the old one is coasted
  always_comb begin
    held_nxt = held_r;
    age_nxt  = age_r;
    if (smp_stb && smp_good) begin
      held_nxt = smp_step;
      age_nxt  = '0;
    end else if (ms_tick && age_r != COAST_END) begin
      age_nxt = age_r + 1'b1;
    end
  end

  // Start out failed: nothing valid has been seen since reset
  always_ff @(posedge clk) begin
    if (rst) begin
      held_r <= rlsm_pkg::STEP_OFF;
      age_r  <= COAST_END;
    end else begin
      held_r <= held_nxt;
      age_r  <= age_nxt;
    end
  end

  assign valid_out = (age_r != COAST_END);
  assign step_out  = valid_out ? held_r : rlsm_pkg::STEP_OFF;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_coast_hold: assert property (
    valid_out && !(smp_stb && smp_good) |=> held_r == $past(held_r))
    else $error("held step changed without a good sample");
  a_fail_at_limit: assert property (
    (age_r == COAST_END - 1'b1) && ms_tick && !(smp_stb && smp_good) |=> !valid_out)
    else $error("channel not failed at coast limit");
  a_fresh_valid: assert property (
    smp_stb && smp_good |=> valid_out && age_r == '0)
    else $error("good sample did not revalidate channel");
  a_invalid_zero: assert property (
    !valid_out |-> step_out == rlsm_pkg::STEP_OFF)
    else $error("invalid channel reports nonzero step");
  c_chan_fails: cover property (valid_out ##1 !valid_out);

endmodule

// *** logic/rlsm_top.sv ***
// Runway light setting monitor: turns lamp-current sensor readings into
// combined edge and centerline step settings for the visual-range path.
// Assumes each sensor gives a one-cycle strobe with its rms reading in mA.
//
// Notes on behaviour
// - Step comes from each channel's measured rms lamp current, never a command.
// - Eight channels, each either a 6.6 A or a 20 A circuit.
// - A missing sample is replaced by that channel's last valid sample.
// - Coast at most 30 s without valid data, then mark the channel failed.
// - A channel with an invalid measurement coasts on its held step and reports step zero only once it is marked failed.
// - Any invalid channel in a multi-regulator set forces that set to zero.
// - With every channel valid, the set takes the lowest channel step.
`timescale 1ns/1ps
module rlsm_top #(
  parameter int unsigned NUM_CH      = rlsm_pkg::NUM_CH,
  parameter int unsigned TICK_CYC    = rlsm_pkg::TICK_CYCLES,
  parameter int unsigned COAST_MS    = rlsm_pkg::COAST_LIMIT_MS,
  parameter int unsigned PERIOD_MS   = rlsm_pkg::SAMPLE_PERIOD_MS
) (
  input  wire logic                                 SYS_CLK,
  input  wire logic                                 SYS_RST,
  input  wire logic [NUM_CH-1:0]                    SMP_STB,
  input  wire logic [NUM_CH-1:0]                    SMP_OK,
  input  wire logic [NUM_CH*rlsm_pkg::CUR_W-1:0]    SMP_CURRENT,
  input  wire logic [NUM_CH-1:0]                    CH_USED,
  input  wire logic [NUM_CH-1:0]                    CH_CKT_TYPE,
  input  wire logic [NUM_CH-1:0]                    CH_SET_MAP,
  output logic      [NUM_CH-1:0]                    CH_VALID,
  output logic      [NUM_CH*rlsm_pkg::STEP_W-1:0]   CH_STEP,
  output logic      [rlsm_pkg::STEP_W-1:0]          EDGE_STEP,
  output logic                                      EDGE_FAIL,
  output logic      [rlsm_pkg::STEP_W-1:0]          CLINE_STEP,
  output logic                                      CLINE_FAIL,
  output logic                                      SET_UPDATE
);

  localparam int unsigned SW = rlsm_pkg::STEP_W;
  localparam int unsigned CW = rlsm_pkg::CUR_W;
  localparam int unsigned TW = $clog2(TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_END = TW'(TICK_CYC - 1);
  localparam logic [rlsm_pkg::PERIOD_W-1:0] PERIOD_END = rlsm_pkg::PERIOD_W'(PERIOD_MS - 1);

  // current to step
  // Steps count thresholds met, so a dim regulator never reads brighter
  function automatic logic [SW-1:0] cur_to_step(input logic [CW-1:0] cur,
                                                input logic            ckt);
    logic [SW-1:0] s;
    s = rlsm_pkg::STEP_OFF;
    for (int k = 0; k < rlsm_pkg::NUM_THR; k++) begin
      if (cur >= ((ckt == rlsm_pkg::CKT_HIGH) ? rlsm_pkg::THR_HIGH[k] :
                                                 rlsm_pkg::THR_LOW[k])) begin
        s = SW'(k + 1);
      end
    end
    return s;
  endfunction

  // circuit range check
  // Readings far above the circuit's full scale point to a wrong type or a bad sensor
  function automatic logic in_range(input logic [CW-1:0] cur, input logic ckt);
    logic [CW:0] lim;
    lim = '0;
    if (ckt == rlsm_pkg::CKT_HIGH) begin
      lim = {1'b0, rlsm_pkg::FS_HIGH_MA} + (rlsm_pkg::FS_HIGH_MA >> rlsm_pkg::OVR_SHIFT);
    end else begin
      lim = {1'b0, rlsm_pkg::FS_LOW_MA} + (rlsm_pkg::FS_LOW_MA >> rlsm_pkg::OVR_SHIFT);
    end
    return {1'b0, cur} <= lim;
  endfunction

  // lowest valid step
  // Returns {fail, step}; an empty set reads step zero without a failure
  function automatic logic [SW:0] set_combine(input logic [NUM_CH-1:0]    member,
                                              input logic [NUM_CH-1:0]    valid,
                                              input logic [NUM_CH*SW-1:0] steps);
    logic          fail;
    logic          any;
    logic [SW-1:0] low;
    fail = 1'b0;
    any  = 1'b0;
    low  = rlsm_pkg::STEP_MAX;
    for (int c = 0; c < NUM_CH; c++) begin
      if (member[c]) begin
        any = 1'b1;
        if (!valid[c]) begin
          fail = 1'b1;
        end else if (steps[c*SW +: SW] < low) begin
          low = steps[c*SW +: SW];
        end
      end
    end
    if (fail || !any) begin
      low = rlsm_pkg::STEP_OFF;
    end
    return {fail, low};
  endfunction

  // Millisecond tick and update-period counters
  logic [TW-1:0]                   tick_cnt_r, tick_cnt_nxt;
  logic [rlsm_pkg::PERIOD_W-1:0]   per_cnt_r,  per_cnt_nxt;
  logic                            ms_tick;
  logic                            period_tick;

  assign ms_tick     = (tick_cnt_r == TICK_END);
  assign period_tick = ms_tick && (per_cnt_r == PERIOD_END);

  always_comb begin
    tick_cnt_nxt = ms_tick ? '0 : tick_cnt_r + 1'b1;
    per_cnt_nxt  = per_cnt_r;
    if (ms_tick) begin
      per_cnt_nxt = (per_cnt_r == PERIOD_END) ? '0 : per_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      tick_cnt_r <= '0;
      per_cnt_r  <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      per_cnt_r  <= per_cnt_nxt;
    end
  end

  // Per-channel trackers; an unused channel is held in reset, so it reads failed
  // at once even if it is dropped mid-run, and needs a fresh sample when reused
  logic [NUM_CH-1:0]    ch_valid;
  logic [NUM_CH*SW-1:0] ch_step;
  logic [NUM_CH-1:0]    ch_good;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [CW-1:0] cur;
    assign cur = SMP_CURRENT[g*CW +: CW];
    assign ch_good[g] = SMP_OK[g] && in_range(cur, CH_CKT_TYPE[g]);
    rlsm_chan #(
      .COAST_MS (COAST_MS)
    ) u_chan (
      .clk       (SYS_CLK),
      .rst       (SYS_RST || !CH_USED[g]),
      .smp_stb   (SMP_STB[g] && CH_USED[g]),
      .smp_good  (ch_good[g]),
      .smp_step  (cur_to_step(cur, CH_CKT_TYPE[g])),
      .ms_tick   (ms_tick),
      .step_out  (ch_step[g*SW +: SW]),
      .valid_out (ch_valid[g])
    );
  end

  logic [NUM_CH-1:0] edge_mem;
  logic [NUM_CH-1:0] cline_mem;
  logic [SW:0]       edge_comb;
  logic [SW:0]       cline_comb;

  assign edge_mem   = CH_USED & ~CH_SET_MAP;
  assign cline_mem  = CH_USED & CH_SET_MAP;
  assign edge_comb  = set_combine(edge_mem, ch_valid, ch_step);
  assign cline_comb = set_combine(cline_mem, ch_valid, ch_step);

  // Published outputs change only at the period boundary, so the consumer
  // sees one coherent snapshot of all channels per update
  logic [NUM_CH-1:0]    chv_r,   chv_nxt;
  logic [NUM_CH*SW-1:0] chs_r,   chs_nxt;
  logic [SW:0]          edge_r,  edge_nxt;
  logic [SW:0]          cline_r, cline_nxt;
  logic                 upd_r,   upd_nxt;

  always_comb begin
    chv_nxt   = chv_r;
    chs_nxt   = chs_r;
    edge_nxt  = edge_r;
    cline_nxt = cline_r;
    upd_nxt   = period_tick;
    if (period_tick) begin
      chv_nxt   = ch_valid;
      chs_nxt   = ch_step;
      edge_nxt  = edge_comb;
      cline_nxt = cline_comb;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      chv_r   <= '0;
      chs_r   <= '0;
      edge_r  <= '0;
      cline_r <= '0;
      upd_r   <= 1'b0;
    end else begin
      chv_r   <= chv_nxt;
      chs_r   <= chs_nxt;
      edge_r  <= edge_nxt;
      cline_r <= cline_nxt;
      upd_r   <= upd_nxt;
    end
  end

  assign CH_VALID   = chv_r;
  assign CH_STEP    = chs_r;
  assign EDGE_FAIL  = edge_r[SW];
  assign EDGE_STEP  = edge_r[SW-1:0];
  assign CLINE_FAIL = cline_r[SW];
  assign CLINE_STEP = cline_r[SW-1:0];
  assign SET_UPDATE = upd_r;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  a_step_from_cur: assert property (
    SMP_STB[0] && CH_USED[0] && ch_good[0] |=>
      ch_step[SW-1:0] == cur_to_step($past(SMP_CURRENT[CW-1:0]), $past(CH_CKT_TYPE[0])))
    else $error("channel 0 step does not follow its current");
  a_over_range: assert property (
    SMP_OK[0] && SMP_CURRENT[CW-1:0] == {CW{1'b1}} |-> !ch_good[0])
    else $error("over-range reading accepted");
  a_over_range_hi: assert property (
    SMP_OK[6] && CH_CKT_TYPE[6] == rlsm_pkg::CKT_HIGH &&
      SMP_CURRENT[6*CW +: CW] >
        rlsm_pkg::FS_HIGH_MA + (rlsm_pkg::FS_HIGH_MA >> rlsm_pkg::OVR_SHIFT)
      |-> !ch_good[6])
    else $error("over-range high-current reading accepted");
  a_edge_zero: assert property (
    period_tick && |(edge_mem & ~ch_valid) |=> EDGE_FAIL && EDGE_STEP == rlsm_pkg::STEP_OFF)
    else $error("edge set not zeroed on invalid member");
  a_cline_low: assert property (
    period_tick && cline_mem != '0 && (cline_mem & ~ch_valid) == '0 |=>
      !CLINE_FAIL && (CLINE_STEP <= CH_STEP[SW-1:0] || !cline_mem[0]))
    else $error("centerline set above a member step");
  a_update_spacing: assert property (
    SET_UPDATE |=> !SET_UPDATE [*2])
    else $error("set update pulses too close");
  a_hold_between: assert property (
    !period_tick |=> $stable(EDGE_STEP) && $stable(CLINE_STEP))
    else $error("set step changed between updates");
  c_edge_fail: cover property (SET_UPDATE && EDGE_FAIL);
  c_cline_ok: cover property (SET_UPDATE && !CLINE_FAIL && CLINE_STEP != rlsm_pkg::STEP_OFF);
  c_all_valid: cover property (SET_UPDATE && CH_VALID == {NUM_CH{1'b1}});

endmodule

// *** tb/rlsm_sensor_model.sv ***
// Lamp-current loop sensor model for eight channels.
// Assumes the bench sets level, validity and presence per channel.
`timescale 1ns/1ps
module rlsm_sensor_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   en,
  input  wire logic [7:0]   good,
  input  wire logic [127:0] amps,
  output logic      [7:0]   stb,
  output logic      [7:0]   ok,
  output logic      [127:0] cur
);
  logic [2:0] cnt_r;

  // rms current report
  // Reports every fifth cycle; between reports the lines toggle, not hold
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 3'h0;
      stb   <= 8'h00;
    end else begin
      cnt_r <= (cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
      stb   <= (cnt_r == 3'h4) ? en : 8'h00;
    end
    ok  <= (cnt_r == 3'h4) ? good : ~ok;
    cur <= (cnt_r == 3'h4) ? amps : ~cur;
  end
endmodule

// *** tb/runway_light_setting_monitor_bench.sv ***
// Bench for the light setting monitor with shortened tick and periods.
// Assumes one update every 12 cycles and a 20-tick (80 cycle) coast.
`timescale 1ns/1ps
module runway_light_setting_monitor_bench;
  logic         clk;
  logic         rst;
  logic [7:0]   en, good, used, ckt, map, stb, ok, vld;
  logic [127:0] amps, cur;
  logic [23:0]  steps;
  logic [2:0]   e_step, c_step;
  logic         e_fail, c_fail, upd;
  int           n_errors, n_tests, cyc;

  rlsm_sensor_model sen (.clk(clk), .rst(rst), .en(en), .good(good),
    .amps(amps), .stb(stb), .ok(ok), .cur(cur));

  rlsm_top #(.TICK_CYC(4), .COAST_MS(20), .PERIOD_MS(3)) dut (
    .SYS_CLK(clk), .SYS_RST(rst), .SMP_STB(stb), .SMP_OK(ok),
    .SMP_CURRENT(cur), .CH_USED(used), .CH_CKT_TYPE(ckt), .CH_SET_MAP(map),
    .CH_VALID(vld), .CH_STEP(steps), .EDGE_STEP(e_step), .EDGE_FAIL(e_fail),
    .CLINE_STEP(c_step), .CLINE_FAIL(c_fail), .SET_UPDATE(upd));

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Waits for n snapshots, bounded so a dead update shows as a mismatch
  task wait_upd(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (upd !== 1'b1 && k < 40);
      chk(upd, 1);
    end
  endtask

  task chk_sets(input logic [2:0] es, input logic ef, input logic [2:0] cs,
                input logic cf);
    chk(e_step, es);
    chk(e_fail, ef);
    chk(c_step, cs);
    chk(c_fail, cf);
  endtask

  // Both circuit types, threshold and over-range edges, min per set
  task t_decode;
    amps <= 128'h5302_4718_24b8_2cec_1b64_12c0_09c4_0c1c;
    en   <= 8'hff;
    wait_upd(2);
    chk(vld, 8'hff);
    chk(steps, 24'hb53b0a);
    chk_sets(3'h1, 1'b0, 3'h2, 1'b0);
    @(negedge clk);
    chk(upd, 0);
  endtask

  // Refused and over-range samples coast, then fail at the limit
  task t_coast;
    good <= 8'hdf;
    amps[111:96] <= 16'h5303;
    // Last good sample lands 70 cycles before the sixth snapshot, expiry falls just before the seventh
    wait_upd(6);
    chk(vld, 8'hff);
    chk(steps, 24'hb53b0a);
    wait_upd(1);
    chk(vld, 8'h9f);
    chk(steps, 24'ha03b0a);
    chk_sets(3'h1, 1'b0, 3'h0, 1'b1);
  endtask

  // Recovery, an unused channel, remapping and an empty set
  task t_remap;
    good <= 8'hff;
    amps[111:96] <= 16'h4718;
    used <= 8'h7f;
    map  <= 8'hf2;
    wait_upd(2);
    chk(vld, 8'h7f);
    chk(steps, 24'h153b0a);
    chk_sets(3'h2, 1'b0, 3'h1, 1'b0);
    @(posedge clk);
    map <= 8'h00;
    wait_upd(2);
    chk_sets(3'h1, 1'b0, 3'h0, 1'b0);
  endtask

  // Hang guard: the run needs about 180 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim;
    end
  end

  // Reset for 20 cycles, then the scenarios in order
  initial begin
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    rst = 1'b1;
    en = 8'h00;
    good = 8'hff;
    used = 8'hff;
    ckt = 8'hf0;
    map = 8'hf0;
    amps = 128'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({24'h000000, vld}, 32'h00000000);
    chk({8'h00, steps}, 32'h00000000);
    chk({23'h000000, e_step, e_fail, c_step, c_fail, upd}, 32'h00000000);
    @(posedge clk);
    t_decode;
    @(posedge clk);
    t_coast;
    @(posedge clk);
    t_remap;
    end_sim;
  end
endmodule
